// [logic/fpp_regs.svh]
/*
  register offsets, field positions and reset values for the flash
  program/erase protection block; assumes a byte-wide register port.
*/
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH
`define FPP_ADDR_CTL      4'h0
`define FPP_ADDR_SEL_LO   4'h1
`define FPP_ADDR_SEL_HI   4'h2
`define FPP_ADDR_OVL      4'h3
`define FPP_ADDR_IRQ_STS  4'h4
`define FPP_ADDR_IRQ_MSK  4'h5
`define FPP_ADDR_STATE    4'h6
`define FPP_CTL_RST       8'h00
`define FPP_SEL_RST       8'h00
`define FPP_OVL_RST       4'h0
`define FPP_OVL_RSVD      3'h7
`define FPP_BIT_WRT_ARM   1
`define FPP_BIT_CLR_ARM   0
`define FPP_BIT_WRT_CHK   3
`define FPP_BIT_CLR_CHK   2
`define FPP_BIT_SUPPLY    7
`define FPP_OVL_SEL_BIT   3
`define FPP_IRQ_FAULT     0
`define FPP_IRQ_PROT      1
`define FPP_IRQ_HWINIT    2
`define FPP_IRQ_W         3
`endif

// [logic/fpp_pkg.sv]
/*
  types for the flash program/erase protection block; no surroundings.
*/
`default_nettype none
package fpp_pkg;
  typedef enum {FPP_IDLE, FPP_PROG, FPP_ERASE, FPP_WVER, FPP_EVER, FPP_PVER} fpp_mode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpp_req_t;
  typedef struct packed {
    logic progEn;
    logic eraseEn;
    logic wrtVerEn;
    logic clrVerEn;
    logic preVerEn;
  } fpp_flash_t;
endpackage
`default_nettype wire

// [logic/fpp_sync2.sv]
/*
  two-flop level synchroniser; assumes an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fpp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  logic stage1_ff;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_ff <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      stage1_ff <= din;
      dout <= stage1_ff;
    end
  end
endmodule
`default_nettype wire

// [logic/fpp_irq.sv]
/*
  sticky event status with mask and write-one-to-clear; assumes
  single-cycle event pulses from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fpp_regs.svh"
module fpp_irq #(
  parameter int W = `FPP_IRQ_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clrMask,
  input wire logic clrWr,
  input wire logic [W-1:0] mskData,
  input wire logic mskWr,
  output logic [W-1:0] sts_ff,
  output logic [W-1:0] msk_ff,
  output logic irq
);
  // set wins over a simultaneous clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sts_ff <= '0;
    else
      sts_ff <= (sts_ff & ~(clrWr ? clrMask : '0)) | evt;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      msk_ff <= '0;
    else if (mskWr)
      msk_ff <= mskData;
  end
  assign irq = |(sts_ff & msk_ff);
endmodule
`default_nettype wire

// [logic/fpp_protect.sv]
/*
  flash program/erase protection: control, block select and overlay
  registers, software and hardware protection, error protect and nmi mask.
  assumes standby/fault/supply inputs from pins or other clock domains,
  and a register master on clk that never issues read and write together.
*/
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpp_regs.svh"
module fpp_protect #(
  parameter int NBLK_LO = 8,
  parameter int NBLK_HI = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire fpp_pkg::fpp_req_t busReq,
  output logic [7:0] rdData_ff,
  input wire logic supplyPin,
  input wire logic hwStandbyPin,
  input wire logic swStandbyReq,
  input wire logic wdtReset,
  input wire logic faultDetect,
  input wire logic nmiIn,
  output logic nmiOut,
  output fpp_pkg::fpp_flash_t flashCtl_ff,
  output logic [NBLK_LO+NBLK_HI-1:0] blkEnable_ff,
  output logic irq
);
  import fpp_pkg::*;

  logic supplySync;
  logic hwStbySync;
  logic faultSync;
  logic [7:0] ctl_ff;
  logic [NBLK_LO-1:0] selLo_ff;
  logic [NBLK_HI-1:0] selHi_ff;
  logic [3:0] ovl_ff;
  logic fault_ff;
  fpp_mode_t mode_ff;
  fpp_mode_t nxt_mode;
  logic regInit;
  logic armAny;
  logic swProt;
  logic blocksOk;
  logic [`FPP_IRQ_W-1:0] irqEvt;
  logic [`FPP_IRQ_W-1:0] irqSts;
  logic [`FPP_IRQ_W-1:0] irqMsk;
  logic refusedArm;
  logic faultEntry;

  fpp_sync2 #(.RST_VAL(1'b0)) uSupply (
    .clk(clk), .nrst(nrst), .din(supplyPin), .dout(supplySync));
  // standby synchroniser resets asserted so nothing arms before release
  fpp_sync2 #(.RST_VAL(1'b1)) uHwStby (
    .clk(clk), .nrst(nrst), .din(hwStandbyPin), .dout(hwStbySync));
  fpp_sync2 #(.RST_VAL(1'b0)) uFault (
    .clk(clk), .nrst(nrst), .din(faultDetect), .dout(faultSync));

  function automatic logic isWr(input fpp_req_t r, input logic [7:0] a);
    isWr = r.wr && (r.addr == a);
  endfunction

  // hardware init sources: missing supply, standby entries, watchdog reset
  assign regInit = !supplySync || hwStbySync || swStandbyReq || wdtReset;
  assign armAny = ctl_ff[`FPP_BIT_WRT_ARM] || ctl_ff[`FPP_BIT_CLR_ARM];
  assign blocksOk = (|selLo_ff) || (|selHi_ff);
  assign swProt = ovl_ff[`FPP_OVL_SEL_BIT] || !blocksOk;
  assign faultEntry = faultSync && armAny && !fault_ff;

  // control register, writable even in error protect
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctl_ff <= `FPP_CTL_RST;
    else if (regInit)
      ctl_ff <= `FPP_CTL_RST;
    else if (isWr(busReq, `FPP_ADDR_CTL))
      ctl_ff <= busReq.wdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      selLo_ff <= NBLK_LO'(`FPP_SEL_RST);
      selHi_ff <= NBLK_HI'(`FPP_SEL_RST);
    end
    else if (regInit)
    begin
      selLo_ff <= NBLK_LO'(`FPP_SEL_RST);
      selHi_ff <= NBLK_HI'(`FPP_SEL_RST);
    end
    else
    begin
      if (isWr(busReq, `FPP_ADDR_SEL_LO))
        selLo_ff <= busReq.wdata[NBLK_LO-1:0];
      if (isWr(busReq, `FPP_ADDR_SEL_HI))
        selHi_ff <= busReq.wdata[NBLK_HI-1:0];
    end
  end

  // overlay bits survive software standby, only hardware standby clears
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ovl_ff <= `FPP_OVL_RST;
    else if (hwStbySync)
      ovl_ff <= `FPP_OVL_RST;
    else if (isWr(busReq, `FPP_ADDR_OVL))
      ovl_ff <= busReq.wdata[3:0];
  end

  // sticky fault: no software path clears it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fault_ff <= 1'b0;
    else if (hwStbySync)
      fault_ff <= 1'b0;
    else if (faultEntry)
      fault_ff <= 1'b1;
  end

  // mode selection; program and erase priority over verify
  always_comb
  begin
    nxt_mode = FPP_IDLE;
    if (regInit)
      nxt_mode = FPP_IDLE;
    else if (armAny)
    begin
      if (fault_ff || faultEntry || swProt)
        nxt_mode = FPP_IDLE;
      else if (ctl_ff[`FPP_BIT_WRT_ARM])
        nxt_mode = FPP_PROG;
      else
        nxt_mode = FPP_ERASE;
    end
    else if (ctl_ff[`FPP_BIT_WRT_CHK])
      nxt_mode = FPP_WVER;
    else if (ctl_ff[`FPP_BIT_CLR_CHK])
      nxt_mode = FPP_EVER;
    else if (ctl_ff[`FPP_BIT_SUPPLY])
      nxt_mode = FPP_PVER;
    else
      nxt_mode = FPP_IDLE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_ff <= FPP_IDLE;
    else
      mode_ff <= nxt_mode;
  end

  // outputs to flash array, registered from nxt_mode on the same edge as mode_ff
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flashCtl_ff <= '0;
      blkEnable_ff <= '0;
    end
    else
    begin
      case (nxt_mode)
        FPP_PROG: flashCtl_ff <= 5'b10000;
        FPP_ERASE: flashCtl_ff <= 5'b01000;
        FPP_WVER: flashCtl_ff <= 5'b00100;
        FPP_EVER: flashCtl_ff <= 5'b00010;
        FPP_PVER: flashCtl_ff <= 5'b00001;
        default: flashCtl_ff <= 5'b00000;
      endcase
      if (nxt_mode == FPP_PROG || nxt_mode == FPP_ERASE)
        blkEnable_ff <= {selHi_ff, selLo_ff};
      else
        blkEnable_ff <= '0;
    end
  end

  // only the nmi path is touched; other logic keeps running
  assign nmiOut = nmiIn && !armAny;

  assign refusedArm = armAny && (nxt_mode == FPP_IDLE) && !regInit;
  assign irqEvt = {regInit, refusedArm, faultEntry};

  fpp_irq #(.W(`FPP_IRQ_W)) uIrq (
    .clk(clk),
    .nrst(nrst),
    .evt(irqEvt),
    .clrMask(busReq.wdata[`FPP_IRQ_W-1:0]),
    .clrWr(isWr(busReq, `FPP_ADDR_IRQ_STS)),
    .mskData(busReq.wdata[`FPP_IRQ_W-1:0]),
    .mskWr(isWr(busReq, `FPP_ADDR_IRQ_MSK)),
    .sts_ff(irqSts),
    .msk_ff(irqMsk),
    .irq(irq)
  );

  // read data one cycle after strobe, zero when idle or unmapped
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdData_ff <= 8'h00;
    else if (!busReq.rd)
      rdData_ff <= 8'h00;
    else
    begin
      case (busReq.addr)
        `FPP_ADDR_CTL: rdData_ff <= ctl_ff;
        `FPP_ADDR_SEL_LO: rdData_ff <= 8'(selLo_ff);
        `FPP_ADDR_SEL_HI: rdData_ff <= 8'(selHi_ff);
        `FPP_ADDR_OVL: rdData_ff <= {fault_ff, `FPP_OVL_RSVD, ovl_ff};
        `FPP_ADDR_IRQ_STS: rdData_ff <= 8'(irqSts);
        `FPP_ADDR_IRQ_MSK: rdData_ff <= 8'(irqMsk);
        `FPP_ADDR_STATE: rdData_ff <= {3'h0, flashCtl_ff};
        default: rdData_ff <= 8'h00;
      endcase
    end
  end

  ovl_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    ovl_ff[`FPP_OVL_SEL_BIT] |=> !flashCtl_ff.progEn && !flashCtl_ff.eraseEn)
    else $error("program or erase under overlay select");
  sel_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (selLo_ff == '0 && selHi_ff == '0) |=> !flashCtl_ff.progEn && !flashCtl_ff.eraseEn)
    else $error("program or erase with no block selected");
  blk_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    !(flashCtl_ff.progEn || flashCtl_ff.eraseEn) |-> blkEnable_ff == '0)
    else $error("block enabled outside program or erase");
  fault_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (faultSync && armAny && !hwStbySync) |=> fault_ff)
    else $error("fault during arm did not set flag");
  fault_abort_a: assert property (@(posedge clk) disable iff (!nrst)
    (faultSync && armAny) |=> !flashCtl_ff.progEn && !flashCtl_ff.eraseEn)
    else $error("operation not aborted on fault");
  fault_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    (faultEntry && !regInit && !busReq.wr) |=> ctl_ff == $past(ctl_ff))
    else $error("control changed on fault entry");
  fault_refuse_a: assert property (@(posedge clk) disable iff (!nrst)
    fault_ff |=> !flashCtl_ff.progEn && !flashCtl_ff.eraseEn)
    else $error("program or erase while fault flag set");
  fault_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
    (fault_ff && !hwStbySync) |=> fault_ff)
    else $error("fault flag cleared without hardware standby");
  verify_ok_a: assert property (@(posedge clk) disable iff (!nrst)
    (fault_ff && !regInit && !armAny && ctl_ff[`FPP_BIT_WRT_CHK]) |=> flashCtl_ff.wrtVerEn)
    else $error("verify refused in error protect");
  init_regs_a: assert property (@(posedge clk) disable iff (!nrst)
    regInit |=> ctl_ff == `FPP_CTL_RST && selLo_ff == '0 && selHi_ff == '0)
    else $error("registers not initialised");
  supply_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (!supplySync)[*2] |-> flashCtl_ff == '0)
    else $error("flash mode active without supply");
  nmi_mask_a: assert property (@(posedge clk) disable iff (!nrst)
    armAny |-> !nmiOut)
    else $error("nmi passed while armed");
endmodule
`default_nettype wire

// [test/fpp_cpu_model.sv]
/*
  register-bus master standing in for cpu software.
  assumes read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module fpp_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdData,
  output fpp_pkg::fpp_req_t busReq
);
  import fpp_pkg::*;
  initial busReq = '0;
  // one-cycle strobes, always a gap edge between requests
  task automatic wrReg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1;
    v = rdData;
  endtask
endmodule
`default_nettype wire

// [test/tb.sv]
/*
  self-checking bench for the protect block.
  assumes the cpu model and design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic supplyPin = 1'b1;
  logic hwStandbyPin = 1'b0;
  logic swStandbyReq = 1'b0;
  logic wdtReset = 1'b0;
  logic faultDetect = 1'b0;
  logic nmiIn = 1'b1;
  logic nmiOut, irq;
  logic [7:0] rdData, lo, hi, c, ovl;
  logic [15:0] blkEnable;
  fpp_req_t busReq;
  fpp_flash_t flashCtl;
  int err_total = 0;
  int n_tests = 0;
  int seed = 41474;
  int cycles = 0;

  fpp_protect fpp_protect_i (.clk(clk), .nrst(nrst), .busReq(busReq), .rdData_ff(rdData),
    .supplyPin(supplyPin), .hwStandbyPin(hwStandbyPin), .swStandbyReq(swStandbyReq),
    .wdtReset(wdtReset), .faultDetect(faultDetect), .nmiIn(nmiIn), .nmiOut(nmiOut),
    .flashCtl_ff(flashCtl), .blkEnable_ff(blkEnable), .irq(irq));
  fpp_cpu_model fpp_cpu_model_i (.clk(clk), .rdData(rdData), .busReq(busReq));

  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // long enough for every scenario several times over
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // {prog, erase, wver, ever, pver}; single-bit control values only
  function automatic logic [4:0] expFlash(input logic [7:0] ctl, input logic blk);
    expFlash = {ctl[1] & ~blk, ctl[0] & ~blk, ctl[3], ctl[2], ctl == 8'h80};
  endfunction

  task automatic w(input logic [7:0] a, input logic [7:0] v);
    fpp_cpu_model_i.wrReg(a, v);
    // let the write's register update settle before anyone samples outputs
    #1;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    fpp_cpu_model_i.rdReg(a, v);
    chk(24'(v), 24'(e));
  endtask

  task automatic cf(input logic [4:0] e, input logic [15:0] b);
    repeat (2) @(posedge clk);
    #1;
    chk({3'h0, flashCtl, blkEnable}, {3'h0, e, (e[4] | e[3]) ? b : 16'h0000});
  endtask

  task automatic pulse(input int j);
    @(posedge clk);
    if (j == 0)
      swStandbyReq <= 1'b1;
    else
      wdtReset <= 1'b1;
    @(posedge clk);
    swStandbyReq <= 1'b0;
    wdtReset <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rc(8'h00, 8'h00);
    rc(8'h03, 8'h70);
    rc(8'h10, 8'h00);
    cf(5'h00, 16'h0000);
    $display("reset values done");
    // first two passes keep one or both select registers empty
    for (int i = 0; i < 8; i++)
    begin
      lo = (i == 0) ? 8'h00 : 8'($random(seed));
      hi = (i < 2) ? 8'h00 : 8'($random(seed));
      c = ($random(seed) & 1) ? 8'h02 : 8'h01;
      w(8'h01, lo);
      w(8'h02, hi);
      w(8'h00, c);
      cf(expFlash(c, {hi, lo} == 16'h0000), {hi, lo});
      chk(24'(nmiOut), 24'h0);
    end
    $display("block select done");
    ovl = 8'h08 | (8'($random(seed)) & 8'h07);
    w(8'h01, 8'hFF);
    w(8'h03, ovl);
    rc(8'h03, 8'h70 | ovl);
    foreach (c[k])
    begin
      w(8'h00, 8'h01 << k);
      cf(expFlash(8'h01 << k, 1'b1), 16'h00FF);
    end
    w(8'h03, 8'h00);
    $display("overlay done");
    @(posedge clk);
    supplyPin <= 1'b0;
    repeat (4) @(posedge clk);
    w(8'h01, 8'hFF);
    w(8'h00, 8'h08);
    rc(8'h00, 8'h00);
    rc(8'h01, 8'h00);
    cf(5'h00, 16'h0000);
    @(posedge clk);
    supplyPin <= 1'b1;
    repeat (4) @(posedge clk);
    for (int j = 0; j < 2; j++)
    begin
      w(8'h01, 8'h55);
      w(8'h00, 8'h08);
      pulse(j);
      rc(8'h00, 8'h00);
      rc(8'h01, 8'h00);
      cf(5'h00, 16'h0000);
    end
    $display("supply and standby done");
    for (int m = 0; m < 2; m++)
    begin
      w(8'h01, 8'h01);
      w(8'h00, 8'h02);
      w(8'h04, 8'h07);
      w(8'h05, 8'h01);
      @(posedge clk);
      faultDetect <= 1'b1;
      repeat (3) @(posedge clk);
      faultDetect <= 1'b0;
      repeat (3) @(posedge clk);
      cf(5'h00, 16'h0000);
      rc(8'h00, 8'h02);
      rc(8'h01, 8'h01);
      rc(8'h03, 8'hF0);
      chk(24'(nmiOut), 24'h0);
      chk(24'(irq), 24'h1);
      w(8'h05, 8'h00);
      chk(24'(irq), 24'h0);
      w(8'h04, 8'h01);
      w(8'h05, 8'h01);
      chk(24'(irq), 24'h0);
      w(8'h00, 8'h01);
      rc(8'h00, 8'h01);
      cf(5'h00, 16'h0000);
      w(8'h00, 8'h08);
      cf(expFlash(8'h08, 1'b1), 16'h0000);
      w(8'h03, 8'h00);
      pulse(0);
      rc(8'h00, 8'h00);
      rc(8'h03, 8'hF0);
      @(posedge clk);
      if (m == 0)
        hwStandbyPin <= 1'b1;
      else
        nrst <= 1'b0;
      repeat (10) @(posedge clk);
      hwStandbyPin <= 1'b0;
      nrst <= 1'b1; // low ten cycles
      repeat (4) @(posedge clk);
      rc(8'h03, 8'h70);
      chk(24'(nmiOut), 24'h1);
    end
    $display("error protect done");
    wrap_up();
  end
endmodule
`default_nettype wire
